// File: bcc_defines.vh
// constants for the bridge capability configuration register slice
`ifndef BCC_DEFINES_VH
`define BCC_DEFINES_VH
// ==========================================================
// register byte offsets
`define BCC_OFF_LINK_TIMING   12'h0D4
`define BCC_OFF_PD_CTL        12'h0D8
`define BCC_OFF_PD_WORD       12'h0DC
`define BCC_OFF_RSVD_FIRST    12'h0E0
`define BCC_OFF_RSVD_LAST     12'h0EC
`define BCC_OFF_MSG_CTL       12'h0F0
`define BCC_OFF_MSG_ADDR_LO   12'h0F4
`define BCC_OFF_MSG_ADDR_HI   12'h0F8
`define BCC_OFF_MSG_PAYLOAD   12'h0FC
`define BCC_OFF_ERR_HDR       12'h100
`define BCC_OFF_ERR_STATUS    12'h104
`define BCC_OFF_ERR_MASK      12'h108
// ==========================================================
// reset and constant field values
`define BCC_RST_CLK_RECOVERY  8'h54
`define BCC_RST_L0S_EXIT      7'h02
`define BCC_RST_L1_EXIT       7'h19
`define BCC_RST_DEBOUNCE      8'h00
`define BCC_PD_CAP_ID         8'h03
`define BCC_PD_NEXT_PTR       8'hF0
`define BCC_MSG_CAP_ID        8'h05
`define BCC_MSG_NEXT_PTR      8'h00
`define BCC_MSG_MM_CAPABLE    3'h0
`define BCC_MSG_ADDR64        1'h1
`define BCC_ERR_CAP_ID        16'h0001
`define BCC_ERR_CAP_VER       4'h1
`define BCC_ERR_NEXT_OFF      12'h150
// implemented uncorrectable error bits: 0,4,12..20
`define BCC_ERR_IMPL_MASK     32'h001FF011
`define BCC_PD_EEPROM_BASE    8'h40
// ==========================================================
// field positions
`define BCC_PD_ADDR_LSB       18
`define BCC_PD_OP_BIT         31
`define BCC_MSG_EN_BIT        16
// ==========================================================
// timing
`define BCC_CLK_PERIOD_PS     5000
`define BCC_DEBOUNCE_UNIT_NS  1000000
`define BCC_CYCLES_PER_MS     ((`BCC_DEBOUNCE_UNIT_NS * 1000) / `BCC_CLK_PERIOD_PS)
`endif

// File: bcc_cap_regs.v
// bridge capability configuration registers D4h..108h with product-data port
`timescale 1ns/1ps
// Overview of operation
// - clock recovery wait, 8-bit RW at D4h bits 7:0, resets 54h.
// - L0s exit latency 14:8 resets 2h, L1 exit 22:16 resets 19h.
// - debounce field 31:24 writable only while hot swap enabled.
// - switch debounced for field+1 milliseconds; field resets zero.
// - product-data capability at D8h, id 03h, next pointer F0h.
// - product-data address in D8h bits 23:18, RW, resets zero.
// - writing op flag 0 starts EEPROM read; flag set to 1 when done.
// - writing op flag 1 starts EEPROM write; flag cleared when done.
// - 32-bit data word at DCh maps EEPROM at address plus 40h.
// - offsets E0h through ECh are reserved and read zero.
// - message interrupt capability at F0h, id 05h, next pointer 00h.
// - message enable bit 16 selects messages over the pin interrupts.
// - multiple message capable 19:17 read-only, resets 000.
// - multiple message enable 22:20 RW, resets 000.
// - 64-bit address capable bit 23 resets 1; bits 31:24 read zero.
// - message address bits 31:2 RW, bits 1:0 read zero.
// - upper message address at F8h, 32-bit RW, resets zero.
// - message data 15:0 at FCh RW, upper bits read zero.
// - error reporting header at 100h: id 0001h, version 1h, next 150h.
// - sticky write-one-to-clear uncorrectable error status at 104h.
// - sticky RW uncorrectable error mask at 108h, same bit positions.
`include "bcc_defines.vh"

module bcc_cap_regs #(
	parameter CYCLES_PER_MS = `BCC_CYCLES_PER_MS,
	parameter EE_AW         = 8
) (
	input  wire        clk,
	input  wire        sys_rst,
	input  wire        pwr_rst,
	input  wire        cfg_wr,
	input  wire        cfg_rd,
	input  wire [11:0] cfg_addr,
	input  wire [3:0]  cfg_be,
	input  wire [31:0] cfg_wdata,
	output reg  [31:0] cfg_rdata,
	output reg         cfg_rvalid,
	input  wire        hot_swap_en,
	input  wire        swap_switch_raw,
	output reg         swap_switch_stable,
	output reg  [7:0]  clock_recovery_wait,
	output reg  [6:0]  l0s_exit_latency,
	output reg  [6:0]  l1_exit_latency,
	output reg         ee_req,
	output reg         ee_write,
	output reg  [EE_AW-1:0] ee_addr,
	output reg  [31:0] ee_wdata,
	input  wire        ee_done,
	input  wire [31:0] ee_rdata,
	input  wire        intx_req,
	output reg         intx_assert,
	output reg         msg_intr_en,
	output reg  [2:0]  msg_multi_en,
	output reg  [63:0] msg_addr,
	output reg  [15:0] msg_payload,
	input  wire [31:0] err_detect,
	output reg         err_report
);

// ==========================================================
// write strobes and byte merge
wire [31:0] be_mask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};
wire        wr_link = cfg_wr && (cfg_addr == `BCC_OFF_LINK_TIMING);
wire        wr_pd   = cfg_wr && (cfg_addr == `BCC_OFF_PD_CTL);
wire        wr_pdw  = cfg_wr && (cfg_addr == `BCC_OFF_PD_WORD);
wire        wr_mctl = cfg_wr && (cfg_addr == `BCC_OFF_MSG_CTL);
wire        wr_malo = cfg_wr && (cfg_addr == `BCC_OFF_MSG_ADDR_LO);
wire        wr_mahi = cfg_wr && (cfg_addr == `BCC_OFF_MSG_ADDR_HI);
wire        wr_mpay = cfg_wr && (cfg_addr == `BCC_OFF_MSG_PAYLOAD);
wire        wr_est  = cfg_wr && (cfg_addr == `BCC_OFF_ERR_STATUS);
wire        wr_emsk = cfg_wr && (cfg_addr == `BCC_OFF_ERR_MASK);

// ==========================================================
// synchronisers for pin inputs
reg hs_en_m_q;
reg hs_en_q;
reg sw_m_q;
reg sw_q;
// only the second stage of each pair is read by the logic below
always @(posedge clk or posedge sys_rst) begin
	if (sys_rst) begin
		hs_en_m_q <= 1'b0;
		hs_en_q   <= 1'b0;
	end else begin
		hs_en_m_q <= hot_swap_en;
		hs_en_q   <= hs_en_m_q;
	end
end

always @(posedge clk or posedge sys_rst) begin
	if (sys_rst) begin
		sw_m_q <= 1'b0;
		sw_q   <= 1'b0;
	end else begin
		sw_m_q <= swap_switch_raw;
		sw_q   <= sw_m_q;
	end
end

// ==========================================================
// link timing and debounce field at D4h
reg [7:0] debounce_q;
always @(posedge clk or posedge sys_rst) begin
	if (sys_rst) begin
		clock_recovery_wait <= `BCC_RST_CLK_RECOVERY;
		l0s_exit_latency    <= `BCC_RST_L0S_EXIT;
		l1_exit_latency     <= `BCC_RST_L1_EXIT;
		debounce_q          <= `BCC_RST_DEBOUNCE;
	end else if (wr_link) begin
		if (cfg_be[0]) begin
			clock_recovery_wait <= cfg_wdata[7:0];
		end
		if (cfg_be[1]) begin
			l0s_exit_latency <= cfg_wdata[14:8];
		end
		if (cfg_be[2]) begin
			l1_exit_latency <= cfg_wdata[22:16];
		end
		// the debounce byte is frozen while the hot-swap pin is low
		if (cfg_be[3] && hs_en_q) begin
			debounce_q <= cfg_wdata[31:24];
		end
	end
end

// ==========================================================
// switch debounce: level must hold for (field + 1) milliseconds
// a new field value only takes effect once the switch level settles again
// limitation: the millisecond base assumes CYCLES_PER_MS matches the clock
reg [31:0] ms_cnt_q;
reg [8:0]  ms_left_q;
wire       ms_tick = (ms_cnt_q == CYCLES_PER_MS - 1);
always @(posedge clk or posedge sys_rst) begin
	if (sys_rst) begin
		ms_cnt_q           <= 32'h00000000;
		ms_left_q          <= 9'h000;
		swap_switch_stable <= 1'b0;
	end else if (sw_q == swap_switch_stable) begin
		// restart the window on every bounce so only a steady level wins
		ms_cnt_q  <= 32'h00000000;
		ms_left_q <= {1'b0, debounce_q} + 9'h001;
	end else if (ms_tick) begin
		ms_cnt_q <= 32'h00000000;
		if (ms_left_q <= 9'h001) begin
			swap_switch_stable <= sw_q;
		end else begin
			ms_left_q <= ms_left_q - 9'h001;
		end
	end else begin
		ms_cnt_q <= ms_cnt_q + 32'h00000001;
	end
end

// ==========================================================
// product-data port: address, op flag, data word, EEPROM cycle
reg [5:0]  pd_addr_q;
reg        pd_op_q;
reg        pd_busy_q;
reg [31:0] pd_word_q;
// the six-bit field lands in the window above the fixed base, no carry out
wire [EE_AW-1:0] pd_addr_sel = cfg_be[2] ? {{(EE_AW-6){1'b0}}, cfg_wdata[23:18]}
                                         : {{(EE_AW-6){1'b0}}, pd_addr_q};
wire [EE_AW-1:0] ee_addr_d   = pd_addr_sel + `BCC_PD_EEPROM_BASE;
always @(posedge clk or posedge sys_rst) begin
	if (sys_rst) begin
		pd_addr_q <= 6'h00;
		pd_op_q   <= 1'b0;
		pd_busy_q <= 1'b0;
		pd_word_q <= 32'h00000000;
		ee_req    <= 1'b0;
		ee_write  <= 1'b0;
		ee_addr   <= {EE_AW{1'b0}};
		ee_wdata  <= 32'h00000000;
	end else begin
		ee_req <= 1'b0;
		if (pd_busy_q) begin
			// writes during a cycle are dropped so the flag keeps its meaning
			if (ee_done) begin
				pd_busy_q <= 1'b0;
				pd_op_q   <= ~pd_op_q;
				if (!ee_write) begin
					pd_word_q <= ee_rdata;
				end
			end
		end else begin
			if (wr_pdw) begin
				pd_word_q <= (pd_word_q & ~be_mask) | (cfg_wdata & be_mask);
			end
			if (wr_pd && cfg_be[2]) begin
				pd_addr_q <= cfg_wdata[23:18];
			end
			if (wr_pd && cfg_be[3]) begin
				pd_op_q   <= cfg_wdata[`BCC_PD_OP_BIT];
				pd_busy_q <= 1'b1;
				ee_req    <= 1'b1;
				ee_write  <= cfg_wdata[`BCC_PD_OP_BIT];
				ee_addr   <= ee_addr_d;
				ee_wdata  <= pd_word_q;
			end
		end
	end
end

// ==========================================================
// message interrupt capability
always @(posedge clk or posedge sys_rst) begin
	if (sys_rst) begin
		msg_intr_en  <= 1'b0;
		msg_multi_en <= 3'h0;
		msg_addr     <= 64'h0000000000000000;
		msg_payload  <= 16'h0000;
	end else begin
		if (wr_mctl && cfg_be[2]) begin
			msg_intr_en  <= cfg_wdata[`BCC_MSG_EN_BIT];
			msg_multi_en <= cfg_wdata[22:20];
		end
		if (wr_malo) begin
			msg_addr[31:2] <= (msg_addr[31:2] & ~be_mask[31:2]) | (cfg_wdata[31:2] & be_mask[31:2]);
		end
		if (wr_mahi) begin
			msg_addr[63:32] <= (msg_addr[63:32] & ~be_mask) | (cfg_wdata & be_mask);
		end
		if (wr_mpay) begin
			msg_payload <= (msg_payload & ~be_mask[15:0]) | (cfg_wdata[15:0] & be_mask[15:0]);
		end
	end
end

// pin interrupts are passed on only while message mode is off
always @(posedge clk or posedge sys_rst) begin
	if (sys_rst) begin
		intx_assert <= 1'b0;
	end else begin
		intx_assert <= intx_req & ~msg_intr_en;
	end
end

// ==========================================================
// uncorrectable error status and mask, sticky: power reset clears them, system reset does not
reg [31:0] err_status_q;
reg [31:0] err_mask_q;
wire [31:0] err_hit  = err_detect & `BCC_ERR_IMPL_MASK;
wire [31:0] err_clr  = wr_est ? (cfg_wdata & be_mask) : 32'h00000000;
wire [31:0] mask_new = ((err_mask_q & ~be_mask) | (cfg_wdata & be_mask)) & `BCC_ERR_IMPL_MASK;
genvar eb;
generate
	for (eb = 0; eb < 32; eb = eb + 1) begin : g_err_bit
		always @(posedge clk or posedge pwr_rst) begin
			if (pwr_rst) begin
				err_status_q[eb] <= 1'b0;
				err_mask_q[eb]   <= 1'b0;
			end else begin
				// a new error in the clearing cycle survives the clear
				err_status_q[eb] <= (err_status_q[eb] & ~err_clr[eb]) | err_hit[eb];
				if (wr_emsk) begin
					err_mask_q[eb] <= mask_new[eb];
				end
			end
		end
	end
endgenerate

always @(posedge clk or posedge pwr_rst) begin
	if (pwr_rst) begin
		err_report <= 1'b0;
	end else begin
		err_report <= |(err_hit & ~err_mask_q);
	end
end

// ==========================================================
// read data: decoded combinationally, then registered so the bus sees a flop
reg [31:0] rd_mux_d;
always @* begin
	rd_mux_d = 32'h00000000;
	case (cfg_addr)
	`BCC_OFF_LINK_TIMING: begin
		rd_mux_d = {debounce_q, 1'b0, l1_exit_latency, 1'b0,
		            l0s_exit_latency, clock_recovery_wait};
	end
	`BCC_OFF_PD_CTL: begin
		rd_mux_d = {pd_op_q, 7'h00, pd_addr_q, 2'b00,
		            `BCC_PD_NEXT_PTR, `BCC_PD_CAP_ID};
	end
	`BCC_OFF_PD_WORD: begin
		rd_mux_d = pd_word_q;
	end
	`BCC_OFF_MSG_CTL: begin
		rd_mux_d = {8'h00, `BCC_MSG_ADDR64, msg_multi_en,
		            `BCC_MSG_MM_CAPABLE, msg_intr_en,
		            `BCC_MSG_NEXT_PTR, `BCC_MSG_CAP_ID};
	end
	`BCC_OFF_MSG_ADDR_LO: begin
		rd_mux_d = {msg_addr[31:2], 2'b00};
	end
	`BCC_OFF_MSG_ADDR_HI: begin
		rd_mux_d = msg_addr[63:32];
	end
	`BCC_OFF_MSG_PAYLOAD: begin
		rd_mux_d = {16'h0000, msg_payload};
	end
	`BCC_OFF_ERR_HDR: begin
		rd_mux_d = {`BCC_ERR_NEXT_OFF, `BCC_ERR_CAP_VER,
		            `BCC_ERR_CAP_ID};
	end
	`BCC_OFF_ERR_STATUS: begin
		rd_mux_d = err_status_q;
	end
	`BCC_OFF_ERR_MASK: begin
		rd_mux_d = err_mask_q;
	end
	default: begin
		rd_mux_d = 32'h00000000;
	end
	endcase
end

always @(posedge clk or posedge sys_rst) begin
	if (sys_rst) begin
		cfg_rdata  <= 32'h00000000;
		cfg_rvalid <= 1'b0;
	end else begin
		cfg_rvalid <= cfg_rd;
		cfg_rdata  <= rd_mux_d;
	end
end

endmodule // bcc_cap_regs

// File: bcc_cap_regs_assertions.sv
// concurrent checks on the capability register slice ports
`timescale 1ns/1ps
module bcc_cap_regs_chk #(
	parameter EE_AW = 8
) (
	input wire             clk,
	input wire             sys_rst,
	input wire             pwr_rst,
	input wire             cfg_wr,
	input wire             cfg_rd,
	input wire [11:0]      cfg_addr,
	input wire [31:0]      cfg_wdata,
	input wire             cfg_rvalid,
	input wire             ee_req,
	input wire             ee_write,
	input wire [EE_AW-1:0] ee_addr,
	input wire             intx_req,
	input wire             intx_assert,
	input wire             msg_intr_en,
	input wire [31:0]      err_detect,
	input wire             err_report
);
	// ==========
	// assertions
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst || pwr_rst);
	a_rd_answer: assert property (cfg_rd |=> cfg_rvalid) else $error("read not answered");
	a_rvalid_cause: assert property (cfg_rvalid |-> $past(cfg_rd)) else $error("stray rvalid");
	a_ee_pulse: assert property (ee_req |=> !ee_req) else $error("eeprom start too long");
	a_ee_source: assert property (ee_req |-> $past(cfg_wr) && $past(cfg_addr) == 12'h0D8)
		else $error("eeprom start without write");
	a_ee_dir: assert property (ee_req |-> ee_write == $past(cfg_wdata[31]))
		else $error("eeprom direction wrong");
	a_ee_window: assert property (ee_req |-> ee_addr[7:6] == 2'h1) else $error("eeprom base");
	a_intx_gate: assert property (!$past(sys_rst) && $stable(msg_intr_en) |->
		intx_assert == ($past(intx_req) && !msg_intr_en)) else $error("pin interrupt gating");
	a_err_cause: assert property (err_report |-> $past(|err_detect)) else $error("stray report");
	c_ee_wr: cover property (ee_req && ee_write);
	c_ee_rd: cover property (ee_req && !ee_write);
	c_err: cover property (err_report);
endmodule // bcc_cap_regs_chk
bind bcc_cap_regs bcc_cap_regs_chk #(.EE_AW(EE_AW)) u_chk (.clk(clk), .sys_rst(sys_rst),
	.pwr_rst(pwr_rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
	.cfg_wdata(cfg_wdata), .cfg_rvalid(cfg_rvalid), .ee_req(ee_req), .ee_write(ee_write),
	.ee_addr(ee_addr), .intx_req(intx_req), .intx_assert(intx_assert),
	.msg_intr_en(msg_intr_en), .err_detect(err_detect), .err_report(err_report));

// File: bcc_ee_model.sv
// eeprom engine model answering product-data cycles
`timescale 1ns/1ps
module bcc_ee_model #(
	parameter LAT = 6
) (
	input wire        clk,
	input wire        ee_req,
	input wire        ee_write,
	input wire [7:0]  ee_addr,
	input wire [31:0] ee_wdata,
	output reg        ee_done = 1'b0,
	output reg [31:0] ee_rdata = 32'h0
);
	// ==========
	// engine
	reg [31:0] mem [0:255];
	reg        wr_q;
	reg [7:0]  a_q;
	integer    cnt = -1;
	always @(posedge clk) begin
		ee_done <= 1'b0;
		// read data toggles so a late sample never looks valid
		ee_rdata <= ~ee_rdata;
		if (ee_req) begin
			cnt <= LAT;
			wr_q <= ee_write;
			a_q <= ee_addr;
		end else if (cnt > 0)
			cnt <= cnt - 1;
		else if (cnt == 0) begin
			cnt <= -1;
			ee_done <= 1'b1;
			if (wr_q)
				mem[a_q] <= ee_wdata;
			else
				ee_rdata <= mem[a_q];
		end
	end
endmodule // bcc_ee_model

// File: test_bcc_cap_regs.sv
// self-checking bench for the capability register slice
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module test_bcc_cap_regs;
	// ==========
	// signals and design
	reg         clk = 0, sys_rst = 1, pwr_rst = 1, cfg_wr = 0, cfg_rd = 0, intx_req = 0;
	reg         hot_swap_en = 0, swap_switch_raw = 0;
	reg [11:0]  cfg_addr = 12'h0;
	reg [3:0]   cfg_be = 4'h0;
	reg [31:0]  cfg_wdata = 32'h0, err_detect = 32'h0, r;
	wire [31:0] cfg_rdata, ee_wdata, ee_rdata;
	wire [7:0]  crw, ee_addr;
	wire [6:0]  l0s, l1;
	wire [2:0]  mme;
	wire [63:0] maddr;
	wire [15:0] mpay;
	wire        men;
	wire        cfg_rvalid, stable, ee_req, ee_write, ee_done, intx_assert, err_report;
	integer     num_errors = 0, total_checks = 0, i;
	reg [11:0]  ta [0:5] = '{12'h0F0, 12'h0F4, 12'h0F8, 12'h0FC, 12'h0E0, 12'h0D4};
	reg [31:0]  te [0:5] = '{32'h00F10005, 32'hFFFFFFFC, 32'hFFFFFFFF, 32'h0000FFFF,
		32'h0, 32'h007F7FFF};
	always #2.5 clk = ~clk;
	bcc_cap_regs #(.CYCLES_PER_MS(4)) uut (.clk(clk), .sys_rst(sys_rst), .pwr_rst(pwr_rst),
		.cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
		.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
		.hot_swap_en(hot_swap_en), .swap_switch_raw(swap_switch_raw),
		.swap_switch_stable(stable), .clock_recovery_wait(crw), .l0s_exit_latency(l0s),
		.l1_exit_latency(l1), .ee_req(ee_req), .ee_write(ee_write), .ee_addr(ee_addr),
		.ee_wdata(ee_wdata), .ee_done(ee_done), .ee_rdata(ee_rdata), .intx_req(intx_req),
		.intx_assert(intx_assert), .msg_intr_en(men), .msg_multi_en(mme), .msg_addr(maddr),
		.msg_payload(mpay), .err_detect(err_detect), .err_report(err_report));
	bcc_ee_model u_ee (.clk(clk), .ee_req(ee_req), .ee_write(ee_write), .ee_addr(ee_addr),
		.ee_wdata(ee_wdata), .ee_done(ee_done), .ee_rdata(ee_rdata));
	// ==========
	// access tasks
	task wr(input [11:0] a, input [3:0] be, input [31:0] d);
		begin
			@(negedge clk);
			{cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, a, be, d};
			@(negedge clk);
			cfg_wr = 0;
		end
	endtask
	task rd(input [11:0] a);
		begin
			@(negedge clk);
			{cfg_rd, cfg_addr} = {1'b1, a};
			@(negedge clk);
			cfg_rd = 0;
			`CHK(cfg_rvalid, 1'b1)
			r = cfg_rdata;
		end
	endtask
	task rc(input [11:0] a, input [31:0] e);
		begin
			rd(a);
			`CHK(r, e)
		end
	endtask
	// poll the operation flag; the engine answers within a few cycles
	task pw(input b);
		begin
			for (i = 0; i < 40 && r[31] !== b; i++)
				rd(12'h0D8);
			`CHK(r[31], b)
		end
	endtask
	task tick(input integer n);
		repeat (n) @(negedge clk);
	endtask
	task summarize;
		begin
			$display("checks %0d errors %0d", total_checks, num_errors);
			if (num_errors == 0 && total_checks > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	initial begin
		#100000;
		num_errors++;
		summarize;
	end
	initial begin
		tick(16);
		sys_rst = 0;
		pwr_rst = 0;
		rc(12'h0D4, 32'h00190254);
		rc(12'h0D8, 32'h0000F003);
		rc(12'h0F0, 32'h00800005);
		rc(12'h100, 32'h15010001);
		rc(12'h108, 32'h0);
		for (i = 0; i < 6; i++) begin
			wr(ta[i], 4'hF, 32'hFFFFFFFF);
			rc(ta[i], te[i]);
		end
		`CHK(l0s, 7'h7F)
		`CHK(l1, 7'h7F)
		`CHK(men, 1'b1)
		`CHK(mme, 3'h7)
		`CHK(maddr, 64'hFFFFFFFFFFFFFFFC)
		`CHK(mpay, 16'hFFFF)
		intx_req = 1;
		tick(3);
		`CHK(intx_assert, 1'b0)
		wr(12'h0F0, 4'hF, 32'h0);
		tick(3);
		`CHK(intx_assert, 1'b1)
		hot_swap_en = 1;
		tick(4);
		wr(12'h0D4, 4'h8, 32'h01000000);
		rc(12'h0D4, 32'h017F7FFF);
		`CHK(crw, 8'hFF)
		swap_switch_raw = 1;
		tick(5);
		`CHK(stable, 1'b0)
		tick(15);
		`CHK(stable, 1'b1)
		wr(12'h0DC, 4'hF, 32'hA5C31234);
		wr(12'h0D8, 4'hC, 32'h80140000);
		rc(12'h0D8, 32'h8014F003);
		pw(1'b0);
		wr(12'h0DC, 4'hF, 32'h0);
		wr(12'h0D8, 4'hC, 32'h00140000);
		rc(12'h0D8, 32'h0014F003);
		pw(1'b1);
		rc(12'h0DC, 32'hA5C31234);
		err_detect = 32'hFFFFFFFF;
		tick(1);
		err_detect = 32'h0;
		`CHK(err_report, 1'b1)
		rc(12'h104, 32'h001FF011);
		sys_rst = 1;
		tick(1);
		sys_rst = 0;
		rc(12'h104, 32'h001FF011);
		wr(12'h104, 4'hF, 32'h00000011);
		rc(12'h104, 32'h001FF000);
		wr(12'h108, 4'hF, 32'hFFFFFFFF);
		rc(12'h108, 32'h001FF011);
		err_detect = 32'h1;
		tick(1);
		err_detect = 32'h0;
		`CHK(err_report, 1'b0)
		summarize;
	end
endmodule // test_bcc_cap_regs
